// ### pkg/qlsd_pkg.sv
`default_nettype none
package qlsd_pkg;
    // Channel and frame geometry
    localparam int NUM_CH = 4;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_STEP = 5'h01;
    localparam logic [4:0] CNT_FIRST_BYTE = 5'h07;
    localparam logic [4:0] CNT_MAX = 5'h10;
    localparam logic [3:0] FAULT_PAD = 4'h0;
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Timing oscillator and fault timing
    localparam int REF_PERIOD_NS = 25;
    localparam int OSC_PERIOD_NS = 500;
    localparam int OSC_W = 5;
    localparam logic [OSC_W-1:0] OSC_LAST =
        OSC_W'((OSC_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS - 1);
    localparam int TMR_W = 13;
    localparam int SENSE_TIME_NS = 62500;
    localparam int SHUTDOWN_TIME_NS = 3940000;
    localparam int OPEN_LOAD_TIME_NS = 12500;
    localparam logic [TMR_W-1:0] SENSE_TICKS = TMR_W'(SENSE_TIME_NS / OSC_PERIOD_NS);
    localparam logic [TMR_W-1:0] SHUTDOWN_TICKS = TMR_W'(SHUTDOWN_TIME_NS / OSC_PERIOD_NS);
    localparam logic [TMR_W-1:0] OPEN_LOAD_TICKS =
        TMR_W'((OPEN_LOAD_TIME_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
    localparam logic [TMR_W-1:0] TMR_ONE = 13'h0001;

    // Analog comparator outputs, one bit per channel
    typedef struct packed {
        logic [NUM_CH-1:0] overcurrent;
        logic [NUM_CH-1:0] open_load;
    } qlsd_sense_s;

    // Supply monitors
    typedef struct packed {
        logic logic_por;
        logic load_supply_bad;
    } qlsd_supply_s;
endpackage
`default_nettype wire

// ### hdl/qlsd_channel.sv
`default_nettype none
module qlsd_channel #(
    parameter logic [qlsd_pkg::TMR_W-1:0] SHUT_TICKS = qlsd_pkg::SHUTDOWN_TICKS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic osc_tick,
    input wire logic clear,
    input wire logic want_on,
    input wire logic cs_rise,
    // Comparators
    input wire logic oc_sense,
    input wire logic ol_sense,
    // Result
    output logic drive_on,
    output logic fault
);
    import qlsd_pkg::*;

    typedef enum logic [1:0] {CH_NORMAL, CH_RETRY_OFF, CH_RETRY_ON} qlsd_ch_state_e;

    localparam logic [TMR_W-1:0] SENSE_LAST = SENSE_TICKS - TMR_ONE;
    localparam logic [TMR_W-1:0] OPEN_LAST = OPEN_LOAD_TICKS - TMR_ONE;
    localparam logic [TMR_W-1:0] SHUT_LAST = SHUT_TICKS - TMR_ONE;

    qlsd_ch_state_e state_reg, state_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic oc_latch_reg, oc_latch_next;
    logic ol_fault_reg, ol_fault_next;
    logic cond, oc_hit, ol_hit;

    ////////////////////////////////////////////////////////////////////////
    // Fault timing and retry
    always_comb begin
        cond = want_on ? oc_sense : ol_sense; // RULE8
        oc_hit = osc_tick && (tmr_reg == SENSE_LAST); // RULE13
        ol_hit = osc_tick && (tmr_reg == OPEN_LAST); // RULE15
        state_next = state_reg;
        ol_fault_next = 1'h0;
        if (!cond) begin
            tmr_next = '0; // RULE26
        end else if (osc_tick) begin
            tmr_next = tmr_reg + TMR_ONE;
        end else begin
            tmr_next = tmr_reg;
        end
        unique case (state_reg)
            CH_NORMAL: begin
                if (want_on && oc_sense && oc_hit) begin
                    state_next = CH_RETRY_OFF; // RULE11
                    tmr_next = '0;
                end
                ol_fault_next = !want_on && ol_sense && (ol_hit || ol_fault_reg); // RULE15 RULE9
            end
            CH_RETRY_OFF: begin
                tmr_next = osc_tick ? tmr_reg + TMR_ONE : tmr_reg; // RULE14
                if (!want_on) begin
                    state_next = CH_NORMAL;
                    tmr_next = '0;
                end else if (osc_tick && tmr_reg == SHUT_LAST) begin
                    state_next = CH_RETRY_ON; // RULE12
                    tmr_next = '0;
                end
            end
            CH_RETRY_ON: begin
                if (!want_on || !oc_sense) begin
                    state_next = CH_NORMAL; // RULE11
                end else if (oc_hit) begin
                    state_next = CH_RETRY_OFF; // RULE12
                    tmr_next = '0;
                end
            end
        endcase
        oc_latch_next = (state_next != CH_NORMAL) || (oc_latch_reg && !cs_rise); // RULE24
        if (clear) begin
            state_next = CH_NORMAL; // RULE17
            tmr_next = '0;
            oc_latch_next = 1'h0;
            ol_fault_next = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= CH_NORMAL;
            tmr_reg <= '0;
            oc_latch_reg <= 1'h0;
            ol_fault_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            oc_latch_reg <= oc_latch_next;
            ol_fault_reg <= ol_fault_next;
        end
    end

    assign drive_on = want_on && (state_reg != CH_RETRY_OFF); // RULE11
    assign fault = oc_latch_reg || ol_fault_reg; // RULE9

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_oc_latch_cause: assert property ($rose(oc_latch_reg) |-> $past(oc_hit)) // RULE13
        else $error("overcurrent latched before sense time");
    a_retry_off_drive: assert property (state_reg == CH_RETRY_OFF |-> !drive_on) // RULE14
        else $error("driver on during shutdown time");
    a_retry_on_time: assert property ($rose(state_reg == CH_RETRY_ON) |-> $past(tmr_reg) == SHUT_LAST) // RULE12
        else $error("retry started before shutdown time");
    a_ol_when_off: assert property ($rose(ol_fault_reg) |-> $past(want_on) == 1'h0) // RULE8
        else $error("open load reported while on");
    a_ol_self_clear: assert property (!ol_sense |=> !ol_fault_reg) // RULE9
        else $error("open load fault did not clear");
    a_oc_held: assert property (oc_latch_reg && !cs_rise && !clear |=> oc_latch_reg) // RULE24
        else $error("overcurrent bit dropped before frame end");
    c_retry_cycle: cover property (state_reg == CH_RETRY_ON ##1 state_reg == CH_RETRY_OFF);
    c_ol_fault: cover property ($rose(ol_fault_reg));
endmodule
`default_nettype wire

// ### hdl/qlsd_serial_ctrl.sv
// Behaviour
// [RULE1] Transaction starts only with chip select low
// [RULE2] Sample serial_in on rising serial clock
// [RULE3] Shift most significant bit first, both ways
// [RULE4] Apply command to drivers on select rise
// [RULE5] Update serial_out on falling serial clock
// [RULE6] serial_out driven only while selected
// [RULE7] Fault flag low on any channel fault
// [RULE8] Overcurrent checked on, open load off
// [RULE9] Fault bit follows fault, clears itself
// [RULE10] Capture fault bits on select fall
// [RULE11] Persistent overcurrent runs low duty retry
// [RULE12] Retry on fraction about 1.56 percent
// [RULE13] Overcurrent must persist for sense time
// [RULE14] Stay off for shutdown time before retry
// [RULE15] Open load must persist before reporting
// [RULE16] Supply over or undervoltage forces outputs off
// [RULE17] Power-on reset holds outputs off, clears state
// [RULE18] Host keeps serial clock at most 4 MHz; the test host model clocks at 6.25 MHz (80 ns high, 80 ns low)
// [RULE19] Host keeps select high 1 us between frames
// [RULE20] Eight-bit command plus four parallel inputs
// [RULE21] Driver on when command or parallel high
// [RULE22] Last four bits received drive the outputs
// [RULE23] Sixteen-bit frame echoes previous first byte
// [RULE24] Overcurrent bit held until select rises
// [RULE25] Fault bits highest channel first, rest zero
// [RULE26] Fault timers run on oscillator, restart
`default_nettype none
module qlsd_serial_ctrl #(
    parameter logic [qlsd_pkg::TMR_W-1:0] SHUT_TICKS = qlsd_pkg::SHUTDOWN_TICKS
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Serial link
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Parallel control
    input wire logic par_in_ch0,
    input wire logic par_in_ch1,
    input wire logic par_in_ch2,
    input wire logic par_in_ch3,
    // Comparators and supply monitors
    input wire qlsd_pkg::qlsd_sense_s sense,
    input wire qlsd_pkg::qlsd_supply_s supply,
    // Drivers
    output logic drive_ch0,
    output logic drive_ch1,
    output logic drive_ch2,
    output logic drive_ch3,
    // Open-drain fault flag
    output logic fault_flag_n,
    output logic fault_flag_n_oe
);
    import qlsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Serial link domain, rising edge
    logic frame_rst_n;
    logic [CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic [7:0] first_byte_reg, first_byte_next;
    logic [7:0] verify_reg, verify_next;

    // Frame state is cleared while deselected
    assign frame_rst_n = reset_n && !chip_select_n; // RULE1

    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        rx_shift_next = rx_shift_reg;
        first_byte_next = first_byte_reg;
        verify_next = verify_reg;
        if (!chip_select_n) begin
            rx_shift_next = {rx_shift_reg[6:0], serial_in}; // RULE2 RULE3
            if (bit_cnt_reg != CNT_MAX) begin
                bit_cnt_next = bit_cnt_reg + CNT_STEP;
            end
            if (bit_cnt_reg == CNT_FIRST_BYTE) begin
                first_byte_next = rx_shift_next;
                verify_next = first_byte_reg; // RULE23
            end
        end
    end

    always_ff @(posedge serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg <= CNT_ZERO;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    always_ff @(posedge serial_clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_shift_reg <= BYTE_RESET;
            first_byte_reg <= BYTE_RESET;
            verify_reg <= BYTE_RESET;
        end else begin
            rx_shift_reg <= rx_shift_next;
            first_byte_reg <= first_byte_next;
            verify_reg <= verify_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial link domain, falling edge
    logic [NUM_CH-1:0] fault_snap_reg, fault_snap_next;
    logic [15:0] tx_word;
    logic sout_reg, sout_next;
    logic started_reg;

    always_comb begin
        tx_word = {fault_snap_reg, FAULT_PAD, verify_reg}; // RULE25 RULE23
        if (bit_cnt_reg < CNT_MAX) begin
            sout_next = tx_word[~bit_cnt_reg[3:0]]; // RULE3
        end else begin
            sout_next = 1'h0;
        end
    end

    always_ff @(negedge serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sout_reg <= 1'h0;
            started_reg <= 1'h0;
        end else begin
            sout_reg <= sout_next; // RULE5
            started_reg <= 1'h1;
        end
    end

    // First bit comes from the frozen snapshot until the first falling edge
    assign serial_out = started_reg ? sout_reg : fault_snap_reg[NUM_CH-1]; // RULE5
    assign serial_out_oe = !chip_select_n; // RULE6

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers into the reference domain
    logic [1:0] cs_sync_reg;
    logic cs_prev_reg;
    logic [NUM_CH-1:0] par_s1_reg, par_s2_reg;
    qlsd_sense_s sense_s1_reg, sense_s2_reg;
    qlsd_supply_s supply_s1_reg, supply_s2_reg;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_sync_reg <= 2'h3;
            cs_prev_reg <= 1'h1;
            par_s1_reg <= '0;
            par_s2_reg <= '0;
            sense_s1_reg <= '0;
            sense_s2_reg <= '0;
            supply_s1_reg <= '0;
            supply_s2_reg <= '0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], chip_select_n};
            cs_prev_reg <= cs_sync_reg[1];
            par_s1_reg <= {par_in_ch3, par_in_ch2, par_in_ch1, par_in_ch0}; // RULE20
            par_s2_reg <= par_s1_reg;
            sense_s1_reg <= sense;
            sense_s2_reg <= sense_s1_reg;
            supply_s1_reg <= supply;
            supply_s2_reg <= supply_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command, drivers, fault flag and timing oscillator
    logic cs_rise, por, ovuv, any_fault;
    logic [3:0] rx_low;
    logic [NUM_CH-1:0] want_on, drive_w, fault_w;
    logic [NUM_CH-1:0] cmd_reg, cmd_next;
    logic [NUM_CH-1:0] drive_reg, drive_next;
    logic flag_oe_reg, flag_oe_next;
    logic [OSC_W-1:0] osc_cnt_reg, osc_cnt_next;
    logic osc_tick_reg, osc_tick_next;

    // Command byte is stable here: rx_shift_reg only shifts while chip_select_n is low
    assign rx_low = rx_shift_reg[3:0];
    assign any_fault = |fault_w;

    always_comb begin
        cs_rise = cs_sync_reg[1] && !cs_prev_reg;
        por = supply_s2_reg.logic_por;
        ovuv = supply_s2_reg.load_supply_bad;
        want_on = (cmd_reg | par_s2_reg) & ~{NUM_CH{ovuv}}; // RULE21 RULE16
        cmd_next = cmd_reg;
        if (cs_rise) begin
            cmd_next = rx_low; // RULE4 RULE22
        end
        fault_snap_next = cs_sync_reg[1] ? fault_w : fault_snap_reg; // RULE10
        drive_next = drive_w & ~{NUM_CH{ovuv}}; // RULE16
        flag_oe_next = any_fault; // RULE7
        osc_tick_next = (osc_cnt_reg == OSC_LAST); // RULE26
        osc_cnt_next = osc_tick_next ? '0 : osc_cnt_reg + OSC_W'(1);
        if (por) begin
            cmd_next = CMD_RESET; // RULE17
            drive_next = '0;
            fault_snap_next = '0;
            flag_oe_next = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_reg <= CMD_RESET;
            drive_reg <= '0;
            fault_snap_reg <= '0;
            flag_oe_reg <= 1'h0;
            osc_cnt_reg <= '0;
            osc_tick_reg <= 1'h0;
        end else begin
            cmd_reg <= cmd_next;
            drive_reg <= drive_next;
            fault_snap_reg <= fault_snap_next;
            flag_oe_reg <= flag_oe_next;
            osc_cnt_reg <= osc_cnt_next;
            osc_tick_reg <= osc_tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        qlsd_channel #(
            .SHUT_TICKS(SHUT_TICKS)
        ) u_channel (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .osc_tick(osc_tick_reg),
            .clear(por),
            .want_on(want_on[i]),
            .cs_rise(cs_rise),
            .oc_sense(sense_s2_reg.overcurrent[i]),
            .ol_sense(sense_s2_reg.open_load[i]),
            .drive_on(drive_w[i]),
            .fault(fault_w[i])
        );
    end

    assign drive_ch0 = drive_reg[0];
    assign drive_ch1 = drive_reg[1];
    assign drive_ch2 = drive_reg[2];
    assign drive_ch3 = drive_reg[3];
    assign fault_flag_n = 1'h0;
    assign fault_flag_n_oe = flag_oe_reg; // RULE7

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_cmd_on_rise: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cs_rise && !por |=> cmd_reg == $past(rx_low)) // RULE22
        else $error("command not taken at select rise");
    a_cmd_stable: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cs_rise && !por |=> $stable(cmd_reg)) // RULE4
        else $error("command changed outside select rise");
    a_supply_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ovuv |=> drive_reg == '0) // RULE16
        else $error("output on during supply fault");
    a_por_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        por |=> cmd_reg == CMD_RESET && drive_reg == '0) // RULE17
        else $error("state kept during power-on reset");
    a_flag_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !por |=> fault_flag_n_oe == $past(any_fault)) // RULE7
        else $error("fault flag does not follow faults");
    a_snap_frozen: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cs_sync_reg[1] && !por |=> $stable(fault_snap_reg)) // RULE10
        else $error("fault snapshot moved during frame");
    a_rx_sample: assert property (@(posedge serial_clock) disable iff (!reset_n)
        !chip_select_n |=> rx_shift_reg[0] == $past(serial_in)) // RULE2
        else $error("serial input not sampled");
    c_frame16: cover property (@(posedge serial_clock) disable iff (!reset_n)
        bit_cnt_reg == CNT_MAX);
    c_cmd_load: cover property (@(posedge ref_clk) disable iff (!reset_n)
        cs_rise && rx_low != 4'h0);
endmodule
`default_nettype wire

// ### dv/qlsd_host_model.sv
`default_nettype none
module qlsd_host_model (
    // Link pins
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic so_line,
    // Frame result
    output logic [15:0] rx_word,
    output logic done
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
        rx_word = 16'h0000;
        done = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One frame of n bits; sel low keeps select high and sends stray clocks
    task automatic xfer(input int n, input logic [15:0] tx, input logic sel);
        #7 chip_select_n = ~sel;
        rx_word = 16'h0000;
        #300;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #80 serial_clock = 1'b1;
            rx_word = {rx_word[14:0], so_line};
            #80 serial_clock = 1'b0;
        end
        #100 chip_select_n = 1'b1;
        serial_in = 1'b0;
        #1100 done = sel;
        #10 done = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### dv/qlsd_serial_ctrl_tb.sv
`default_nettype none
module qlsd_serial_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import qlsd_pkg::*;

    logic ref_clk, reset_n, serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe;
    logic fault_flag_n, fault_flag_n_oe, so_q, done;
    logic [3:0] par, drv, cmd, flt;
    logic [7:0] echo;
    logic [15:0] rx_word;
    qlsd_sense_s sense;
    qlsd_supply_s supply;
    logic [19:0] notes[$];
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    wire so_line = serial_out_oe ? serial_out : ~so_q;
    wire flag_line = fault_flag_n_oe ? fault_flag_n : 1'b1;

    qlsd_serial_ctrl #(.SHUT_TICKS(13'h0010)) i_qlsd_serial_ctrl (
        .ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .par_in_ch0(par[0]), .par_in_ch1(par[1]),
        .par_in_ch2(par[2]), .par_in_ch3(par[3]), .sense(sense), .supply(supply),
        .drive_ch0(drv[0]), .drive_ch1(drv[1]), .drive_ch2(drv[2]), .drive_ch3(drv[3]),
        .fault_flag_n(fault_flag_n), .fault_flag_n_oe(fault_flag_n_oe)
    );

    qlsd_host_model i_qlsd_host_model (
        .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
        .so_line(so_line), .rx_word(rx_word), .done(done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, released line model, timeout
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    initial so_q = 1'b0;
    always @(posedge ref_clk) if (serial_out_oe) so_q <= serial_out;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checking
    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge done) begin
        chk("frame", notes.pop_front(), {rx_word, drv});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Driving
    task automatic frame(input int n, input logic [15:0] tx);
        logic [15:0] s;
        s = {flt, 4'h0, echo};
        cmd = tx[3:0];
        notes.push_back({s >> (16 - n), cmd | par});
        if (n >= 8) echo = 8'(tx >> (n - 8));
        i_qlsd_host_model.xfer(n, tx, 1'b1);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    initial begin
        reset_n = 1'b0;
        par = 4'h0;
        sense = '0;
        supply = '0;
        cmd = 4'h0;
        flt = 4'h0;
        echo = 8'h00;
        void'($urandom(62751));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        wait_clk(4);
        chk("drives", 20'h00000, drv);
        chk("flag", 20'h00001, flag_line);
        chk("so_oe", 20'h00000, serial_out_oe);
        for (int k = 0; k < 6; k++) frame(k[0] ? 16 : 8, 16'($urandom));
        @(negedge ref_clk) par = 4'($urandom);
        frame(8, 16'h0000);
        frame(16, 16'($urandom));
        i_qlsd_host_model.xfer(16, 16'($urandom), 1'b0);
        chk("drives", 20'(cmd | par), drv);
        frame(16, 16'h5A0F);
        @(negedge ref_clk) par = 4'h0;
        // Open load on all channels, ch0 on
        frame(8, 16'h0001);
        @(negedge ref_clk) sense.open_load = 4'hF;
        wait_clk(400);
        chk("flag", 20'h00001, flag_line);
        wait_clk(300);
        chk("flag", 20'h00000, flag_line);
        flt = 4'hE;
        frame(8, 16'h0001);
        @(negedge ref_clk) sense.open_load = 4'h0;
        wait_clk(10);
        chk("flag", 20'h00001, flag_line);
        flt = 4'h0;
        frame(8, 16'h0001);
        // Overcurrent on ch2 (on) and ch3 (off)
        frame(8, 16'h0004);
        @(negedge ref_clk) sense.overcurrent = 4'hC;
        wait_clk(2400);
        chk("drives", 20'h00004, drv);
        wait_clk(200);
        chk("drives", 20'h00000, drv);
        chk("flag", 20'h00000, flag_line);
        wait_clk(100);
        chk("drives", 20'h00000, drv);
        wait_clk(250);
        chk("drives", 20'h00004, drv);
        @(negedge ref_clk) sense.overcurrent = 4'h0;
        wait_clk(10);
        flt = 4'h4;
        frame(8, 16'h0004);
        flt = 4'h0;
        frame(8, 16'h0004);
        // Supply faults and power-on reset
        frame(8, 16'h000F);
        @(negedge ref_clk) supply.load_supply_bad = 1'b1;
        wait_clk(10);
        chk("drives", 20'h00000, drv);
        @(negedge ref_clk) supply.load_supply_bad = 1'b0;
        wait_clk(10);
        chk("drives", 20'h0000F, drv);
        @(negedge ref_clk) supply.logic_por = 1'b1;
        wait_clk(10);
        chk("drives", 20'h00000, drv);
        @(negedge ref_clk) supply.logic_por = 1'b0;
        wait_clk(10);
        chk("drives", 20'h00000, drv);
        frame(8, 16'h0003);
        stop_test();
    end
endmodule
`default_nettype wire
